/* rtl/cpr_pkg.sv */
package cpr_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL0 = 8'h00;
   localparam logic [7:0] OFS_CTRL1 = 8'h04;
   localparam logic [7:0] OFS_RFLG = 8'h08;
   localparam logic [7:0] OFS_RIER = 8'h0C;
   localparam logic [7:0] OFS_TFLG = 8'h10;
   localparam logic [7:0] OFS_TIER = 8'h14;
   localparam logic [7:0] OFS_MISC = 8'h18;
   localparam logic [2:0] IDX_LAST = 3'h6;

   // Control register 0 fields
   localparam int B_INIT_REQUEST = 0;
   localparam int B_SLEEPRQ = 1;
   localparam int B_WAKEEN = 2;
   localparam int B_SIW = 3;
   localparam int B_INITACK = 4;
   localparam int B_SLEEPACK = 5;
   localparam int B_MODEN = 7;
   // Control register 1 fields
   localparam int B_WFILT = 0;
   localparam int B_BORSEL = 1;
   // Receive flag / enable fields
   localparam int B_RXF = 0;
   localparam int B_OVR = 1;
   localparam int B_TX_STATE_FIELD = 2;
   localparam int B_RX_STATE_FIELD = 4;
   localparam int B_SC = 6;
   localparam int B_WAKE = 7;
   // Misc register fields
   localparam int B_BUSOFF_HOLD = 0;
   localparam int B_BUSOFF = 1;

   // Error-counter state codes
   localparam logic [1:0] ERR_OK = 2'h0;
   localparam logic [1:0] ERR_BUSOFF = 2'h3;

   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int RECOV_TIME_NS = 2000;
   localparam int WAKE_FILT_NS = 500;
   localparam int RECOV_CYCLES = (RECOV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAKE_FILT_CYCLES = (WAKE_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] RESYNC_BITS = 4'hB;
   localparam logic [7:0] BUSOFF_OCC = 8'h80;

   // Reset values
   localparam logic RST_INIT_REQUEST = 1'b1;
   localparam logic RST_MODEN = 1'b0;

   typedef enum logic [2:0] {
      CPR_NORMAL,
      CPR_INIT,
      CPR_SLEEP,
      CPR_RESYNC,
      CPR_RECOVER,
      CPR_PDOWN
   } cpr_mode_t;
endpackage

/* rtl/cpr_ctrl.sv */
// Functional notes
// - Power-down on stop, or wait with stop_in_wait
// - Power-down aborts traffic, transmit goes recessive
// - Power-down stops clocks, registers inaccessible
// - Power-down without sleep runs fixed recovery
// - Wake enable lets bus activity end sleep
// - Wake filter suppresses short receive glitches
// - Four interrupts, local enable plus global mask
// - Error from status/overrun, transmit from empties
// - Empty flag set when buffer free
// - Receive-full set per foreground message load
// - Wake flag set on sleep activity if enabled
// - Status change flagged, states reported in fields
// - Interrupt held while any flag set
// - Receive/transmit flags cleared by writing one
// - Flag not cleared while condition holds
// - Wake recovery needs sleep, enable, irq enable
// - Default automatic bus-off recovery after 128x11
// - User mode also waits for hold clear
// - Sleep shown by request and acknowledge set
// - After wake, wait 11 recessive bits
module cpr_ctrl
   import cpr_pkg::*;
#(
   parameter int RECOV_CYC = RECOV_CYCLES,
   parameter int FILT_CYC = WAKE_FILT_CYCLES
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // Processor state
   input wire logic cpuStop,
   input wire logic cpuWait,
   input wire logic cpuIrqMask,
   // Protocol engine
   input wire logic coreTx,
   input wire logic coreIdle,
   input wire logic bitTick,
   input wire logic rxFgLoad,
   input wire logic rxOverrunEvt,
   input wire logic [2:0] txDoneEvt,
   input wire logic [1:0] txErrState,
   input wire logic [1:0] rxErrState,
   output logic coreRun,
   output logic coreAbort,
   output logic [2:0] txSchedule,
   output logic busOffRecover,
   output logic inBusOff,
   // CAN pins
   input wire logic bus_rx_in,
   output logic bus_tx_out,
   // Interrupts and wake
   output logic wakeUpReq,
   output logic irqWake,
   output logic irqErr,
   output logic irqRx,
   output logic irqTx
);

   typedef struct packed {
      cpr_mode_t mode;
      logic initRequest;
      logic sleepRequest;
      logic wakeEnable;
      logic stopInWait;
      logic moduleEnable;
      logic wakeFilterSel;
      logic busoffRecoverySel;
      logic busoffHold;
      logic wakeFlag;
      logic statusChangeFlag;
      logic overrunFlag;
      logic rxFullFlag;
      logic [1:0] txStateField;
      logic [1:0] rxStateField;
      logic wakeIrqEn;
      logic statusChangeIrqEn;
      logic overrunIrqEn;
      logic rxFullIrqEn;
      logic [2:0] txBufEmptyFlag;
      logic [2:0] txEmptyIrqEn;
      logic slept;
      logic [15:0] tmr;
      logic [15:0] filt;
      logic [3:0] runBits;
      logic [7:0] occ;
      logic busOff;
      logic dWr;
      logic dOk;
      logic [2:0] dIdx;
      logic rdPend;
      logic rOk;
      logic [2:0] rIdx;
      logic hreadyout;
      logic [31:0] hrdata;
      logic busTx;
      logic coreRun;
      logic abort;
      logic recover;
      logic wakeReq;
      logic irqWake;
      logic irqErr;
      logic irqRx;
      logic irqTx;
      logic [2:0] txSched;
   } cpr_regs_t;

   cpr_regs_t s;
   cpr_regs_t next_s;

   // Word index decode, bit 3 marks a mapped address
   function automatic logic [3:0] decIdx(input logic [31:0] a);
      logic ok;
      ok = (a[31:5] == 27'h000_0000) && (a[1:0] == 2'h0) && (a[4:2] <= IDX_LAST);
      return {ok, a[4:2]};
   endfunction

   localparam logic [2:0] I_CTRL0 = OFS_CTRL0[4:2];
   localparam logic [2:0] I_CTRL1 = OFS_CTRL1[4:2];
   localparam logic [2:0] I_RFLG = OFS_RFLG[4:2];
   localparam logic [2:0] I_RIER = OFS_RIER[4:2];
   localparam logic [2:0] I_TFLG = OFS_TFLG[4:2];
   localparam logic [2:0] I_TIER = OFS_TIER[4:2];
   localparam logic [2:0] I_MISC = OFS_MISC[4:2];

   logic pd;
   logic act;
   logic addrPh;
   logic wr;
   logic [7:0] rClr;
   logic [2:0] tClr;
   logic wakeSet;
   logic scSet;
   logic boEnter;
   logic [7:0] rv;

   always_comb begin
      next_s = s;
      next_s.abort = 1'b0;
      next_s.recover = 1'b0;
      rClr = 8'h00;
      tClr = 3'h0;
      wakeSet = 1'b0;
      rv = 8'h00;
      pd = cpuStop | (cpuWait & s.stopInWait);
      wr = s.dWr & s.dOk & (s.mode != CPR_PDOWN);

      if ((s.mode == CPR_SLEEP || s.mode == CPR_PDOWN) && !bus_rx_in) begin
         if (s.filt < 16'(FILT_CYC)) begin
            next_s.filt = s.filt + 16'h0001;
         end
      end else begin
         next_s.filt = 16'h0000;
      end
      act = s.wakeEnable & (s.wakeFilterSel ? (s.filt >= 16'(FILT_CYC)) : !bus_rx_in);

      // Register writes in the data phase
      if (wr) begin
         case (s.dIdx)
            I_CTRL0: begin
               next_s.initRequest = hwdata[B_INIT_REQUEST] | (s.initRequest & s.mode != CPR_INIT);
               next_s.sleepRequest = hwdata[B_SLEEPRQ]
                  | (s.sleepRequest & s.mode != CPR_SLEEP & s.mode != CPR_INIT);
               next_s.wakeEnable = hwdata[B_WAKEEN];
               next_s.stopInWait = hwdata[B_SIW];
               next_s.moduleEnable = hwdata[B_MODEN];
            end
            I_CTRL1: begin
               next_s.wakeFilterSel = hwdata[B_WFILT];
               next_s.busoffRecoverySel = hwdata[B_BORSEL];
            end
            I_RFLG: rClr = hwdata[7:0];
            I_RIER: begin
               next_s.rxFullIrqEn = hwdata[B_RXF];
               next_s.overrunIrqEn = hwdata[B_OVR];
               next_s.statusChangeIrqEn = hwdata[B_SC];
               next_s.wakeIrqEn = hwdata[B_WAKE];
            end
            I_TFLG: tClr = hwdata[2:0];
            I_TIER: next_s.txEmptyIrqEn = hwdata[2:0];
            I_MISC: next_s.busoffHold = hwdata[B_BUSOFF_HOLD];
            default: begin
            end
         endcase
      end

      // Operating mode sequencing
      case (s.mode)
         CPR_NORMAL: begin
            if (!s.moduleEnable || s.initRequest) begin
               next_s.mode = CPR_INIT;
            end else if (s.sleepRequest && coreIdle) begin
               next_s.mode = CPR_SLEEP;
            end
         end
         CPR_INIT: begin
            if (s.moduleEnable && !s.initRequest) begin
               next_s.mode = CPR_NORMAL;
            end
         end
         CPR_SLEEP: begin
            if (s.initRequest) begin
               next_s.mode = CPR_INIT;
            end else if (!s.sleepRequest) begin
               next_s.mode = CPR_RESYNC;
               next_s.runBits = 4'h0;
            end else if (act) begin
               wakeSet = 1'b1;
               next_s.sleepRequest = 1'b0;
               next_s.mode = CPR_RESYNC;
               next_s.runBits = 4'h0;
            end
         end
         CPR_RESYNC: begin
            if (s.runBits == RESYNC_BITS) begin
               next_s.mode = CPR_NORMAL;
               next_s.runBits = 4'h0;
            end
         end
         CPR_RECOVER: begin
            if (s.tmr == 16'h0000) begin
               next_s.mode = CPR_NORMAL;
            end else begin
               next_s.tmr = s.tmr - 16'h0001;
            end
         end
         CPR_PDOWN: begin
            if (s.slept && act) begin
               wakeSet = 1'b1;
            end
            if (!pd) begin
               if (s.slept) begin
                  next_s.mode = CPR_SLEEP;
               end else begin
                  next_s.mode = CPR_RECOVER;
                  next_s.tmr = 16'(RECOV_CYC - 1);
               end
            end
         end
         default: next_s.mode = CPR_INIT;
      endcase

      if (pd && s.mode != CPR_PDOWN) begin
         next_s.mode = CPR_PDOWN;
         next_s.slept = (s.mode == CPR_SLEEP);
         next_s.abort = (s.mode != CPR_SLEEP);
      end

      // Recessive run counter on sampled bits
      if (bitTick && (s.mode == CPR_NORMAL || s.mode == CPR_RESYNC)) begin
         if (!bus_rx_in) begin
            next_s.runBits = 4'h0;
         end else if (s.runBits != RESYNC_BITS) begin
            next_s.runBits = s.runBits + 4'h1;
         end
      end

      boEnter = (txErrState == ERR_BUSOFF) && (s.txStateField != ERR_BUSOFF);
      if (s.busOff && s.mode == CPR_NORMAL && s.runBits == RESYNC_BITS) begin
         next_s.runBits = 4'h0;
         if (s.occ != BUSOFF_OCC) begin
            next_s.occ = s.occ + 8'h01;
         end
      end
      // user mode waits for hold release
      if (s.busOff && s.occ == BUSOFF_OCC && (!s.busoffRecoverySel || !s.busoffHold)) begin
         next_s.busOff = 1'b0;
         next_s.recover = 1'b1;
         next_s.occ = 8'h00;
      end
      if (boEnter) begin
         next_s.busOff = 1'b1;
         next_s.occ = 8'h00;
         // Runs seen before bus-off do not count
         next_s.runBits = 4'h0;
         if (s.busoffRecoverySel) begin
            next_s.busoffHold = 1'b1;
         end
      end

      scSet = ((txErrState != s.txStateField) && (txErrState != ERR_OK))
            || ((rxErrState != s.rxStateField) && (rxErrState != ERR_OK));
      next_s.txStateField = txErrState;
      next_s.rxStateField = rxErrState;

      // set wins over a same-cycle clear
      next_s.wakeFlag = (s.wakeFlag & ~rClr[B_WAKE]) | wakeSet;
      next_s.statusChangeFlag = (s.statusChangeFlag & ~rClr[B_SC]) | scSet;
      next_s.overrunFlag = (s.overrunFlag & ~rClr[B_OVR]) | rxOverrunEvt;
      next_s.rxFullFlag = (s.rxFullFlag & ~rClr[B_RXF]) | rxFgLoad;
      // empty flag set when buffer freed
      next_s.txBufEmptyFlag = (s.txBufEmptyFlag & ~tClr) | txDoneEvt;
      next_s.txSched = ~next_s.txBufEmptyFlag;

      next_s.irqWake = !cpuIrqMask & next_s.wakeFlag & next_s.wakeIrqEn;
      next_s.irqErr = !cpuIrqMask & ((next_s.statusChangeFlag & next_s.statusChangeIrqEn)
                                   | (next_s.overrunFlag & next_s.overrunIrqEn));
      next_s.irqRx = !cpuIrqMask & next_s.rxFullFlag & next_s.rxFullIrqEn;
      next_s.irqTx = !cpuIrqMask & |(next_s.txBufEmptyFlag & next_s.txEmptyIrqEn);
      next_s.wakeReq = (next_s.mode == CPR_PDOWN) & next_s.slept & next_s.wakeEnable
                     & next_s.wakeIrqEn & act;

      next_s.busTx = (next_s.mode == CPR_NORMAL) ? coreTx : 1'b1;
      // clocks stopped in power-down, sleep and init
      next_s.coreRun = (next_s.mode == CPR_NORMAL) || (next_s.mode == CPR_RESYNC)
                     || (next_s.mode == CPR_RECOVER);

      // AHB address phase capture
      addrPh = hsel & htrans[1] & hready;
      next_s.dWr = addrPh & hwrite;
      {next_s.dOk, next_s.dIdx} = decIdx(haddr);
      if (addrPh && !hwrite) begin
         next_s.rdPend = 1'b1;
         next_s.rOk = next_s.dOk;
         next_s.rIdx = next_s.dIdx;
         next_s.hreadyout = 1'b0;
      end

      // Read data two cycles after the address phase, after one wait state
      case (s.rIdx)
         I_CTRL0: begin
            rv[B_INIT_REQUEST] = s.initRequest;
            rv[B_SLEEPRQ] = s.sleepRequest;
            rv[B_WAKEEN] = s.wakeEnable;
            rv[B_SIW] = s.stopInWait;
            rv[B_INITACK] = (s.mode == CPR_INIT);
            rv[B_SLEEPACK] = (s.mode == CPR_SLEEP);
            rv[B_MODEN] = s.moduleEnable;
         end
         I_CTRL1: begin
            rv[B_WFILT] = s.wakeFilterSel;
            rv[B_BORSEL] = s.busoffRecoverySel;
         end
         I_RFLG: begin
            rv[B_RXF] = s.rxFullFlag;
            rv[B_OVR] = s.overrunFlag;
            rv[B_TX_STATE_FIELD +: 2] = s.txStateField;
            rv[B_RX_STATE_FIELD +: 2] = s.rxStateField;
            rv[B_SC] = s.statusChangeFlag;
            rv[B_WAKE] = s.wakeFlag;
         end
         I_RIER: begin
            rv[B_RXF] = s.rxFullIrqEn;
            rv[B_OVR] = s.overrunIrqEn;
            rv[B_SC] = s.statusChangeIrqEn;
            rv[B_WAKE] = s.wakeIrqEn;
         end
         I_TFLG: rv[2:0] = s.txBufEmptyFlag;
         I_TIER: rv[2:0] = s.txEmptyIrqEn;
         I_MISC: begin
            rv[B_BUSOFF_HOLD] = s.busoffHold;
            rv[B_BUSOFF] = s.busOff;
         end
         default: rv = 8'h00;
      endcase
      if (s.rdPend) begin
         next_s.rdPend = 1'b0;
         next_s.hreadyout = 1'b1;
         next_s.hrdata = (s.rOk && s.mode != CPR_PDOWN) ? {24'h00_0000, rv} : 32'h0000_0000;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s <= '0;
         s.mode <= CPR_INIT;
         s.initRequest <= RST_INIT_REQUEST;
         s.moduleEnable <= RST_MODEN;
         s.txBufEmptyFlag <= 3'h7;
         s.hreadyout <= 1'b1;
         s.busTx <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign hreadyout = s.hreadyout;
   assign hrdata = s.hrdata;
   assign hresp = 1'b0;
   assign coreRun = s.coreRun;
   assign coreAbort = s.abort;
   assign txSchedule = s.txSched;
   assign busOffRecover = s.recover;
   assign inBusOff = s.busOff;
   assign bus_tx_out = s.busTx;
   assign wakeUpReq = s.wakeReq;
   assign irqWake = s.irqWake;
   assign irqErr = s.irqErr;
   assign irqRx = s.irqRx;
   assign irqTx = s.irqTx;

endmodule

/* bench/cpr_ctrl_assertions.sv */
module cpr_ctrl_assertions (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Bus
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic hresp,
   // Processor and engine
   input wire logic cpuStop,
   input wire logic cpuWait,
   input wire logic cpuIrqMask,
   input wire logic [2:0] txDoneEvt,
   input wire logic [2:0] txSchedule,
   input wire logic coreRun,
   input wire logic coreAbort,
   input wire logic busOffRecover,
   input wire logic bus_tx_out,
   // Interrupts
   input wire logic irqWake,
   input wire logic irqErr,
   input wire logic irqRx,
   input wire logic irqTx
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   chk_read_wait: assert property (hsel && htrans[1] && !hwrite && hready
      |=> !hreadyout ##1 hreadyout) else $error("read wait state wrong");
   chk_write_nowait: assert property (hsel && htrans[1] && hwrite && hready |=> hreadyout)
      else $error("write stalled");
   chk_rdata_upper: assert property (hreadyout |-> hrdata[31:8] == 24'h00_0000)
      else $error("read data upper bits set");
   chk_resp_okay: assert property (hresp == 1'b0) else $error("error response");
   chk_stop_recessive: assert property (cpuStop |=> bus_tx_out)
      else $error("transmit not recessive in power-down");
   chk_stop_halt: assert property (cpuStop [*3] |-> !coreRun)
      else $error("engine runs in power-down");
   chk_mask_gate: assert property (cpuIrqMask [*2] |-> !(irqWake || irqErr || irqRx || irqTx))
      else $error("interrupt passes global mask");
   chk_abort_once: assert property (coreAbort |-> bus_tx_out ##1 !coreAbort)
      else $error("abort pulse wrong");
   chk_tx_freed: assert property ((|txDoneEvt) && !cpuStop && !cpuWait
      |=> (txSchedule & $past(txDoneEvt)) == 3'h0) else $error("freed buffer still scheduled");
   chk_recover_pulse: assert property (busOffRecover |=> !busOffRecover)
      else $error("recovery pulse too long");
endmodule

/* bench/cpr_bus_model.sv */
module cpr_bus_model #(
   parameter int TICK_DIV = 4
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Other node and own transmit
   input wire logic domReq,
   input wire logic txLevel,
   // Bus view
   output logic busRx,
   output logic bitTick
);
   timeunit 1ns;
   timeprecision 1ps;
   int divCnt;
   // Wired-AND: any dominant node wins
   assign busRx = txLevel & ~domReq;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         divCnt <= 0;
         bitTick <= 1'b0;
      end else begin
         divCnt <= (divCnt == TICK_DIV - 1) ? 0 : divCnt + 1;
         bitTick <= (divCnt == TICK_DIV - 1);
      end
   end
endmodule

/* bench/can_power_irq_recovery_ctrl_test.sv */
`define CHK(nm, e, g) begin nChecks++; if ((g) !== (e)) begin errorCnt++; \
   $display("unexpected %s: expected %h, seen %h", nm, (e), (g)); end end
module can_power_irq_recovery_ctrl_test import cpr_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int RCY = 4;
   localparam int TDIV = 4;
   logic core_clk, rst_n, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rdv;
   logic [1:0] htrans, txErrState, rxErrState;
   logic [2:0] hsize, txDoneEvt, txSchedule, m, e;
   logic cpuStop, cpuWait, cpuIrqMask, coreTx, coreIdle, bitTick, rxFgLoad, rxOverrunEvt;
   logic coreRun, coreAbort, busOffRecover, inBusOff, bus_rx_in, bus_tx_out, busDom;
   logic wakeUpReq, irqWake, irqErr, irqRx, irqTx;
   int errorCnt = 0;
   int nChecks = 0;
   int cycles = 0;
   int k;
   assign hready = hreadyout;

   cpr_ctrl #(.RECOV_CYC(RCY), .FILT_CYC(3)) dut_u (.core_clk(core_clk), .rst_n(rst_n),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .cpuStop(cpuStop), .cpuWait(cpuWait), .cpuIrqMask(cpuIrqMask),
      .coreTx(coreTx), .coreIdle(coreIdle), .bitTick(bitTick), .rxFgLoad(rxFgLoad),
      .rxOverrunEvt(rxOverrunEvt), .txDoneEvt(txDoneEvt), .txErrState(txErrState),
      .rxErrState(rxErrState), .coreRun(coreRun), .coreAbort(coreAbort),
      .txSchedule(txSchedule), .busOffRecover(busOffRecover), .inBusOff(inBusOff),
      .bus_rx_in(bus_rx_in), .bus_tx_out(bus_tx_out), .wakeUpReq(wakeUpReq),
      .irqWake(irqWake), .irqErr(irqErr), .irqRx(irqRx), .irqTx(irqTx));
   cpr_bus_model #(.TICK_DIV(TDIV)) bus_u (.core_clk(core_clk), .rst_n(rst_n),
      .domReq(busDom), .txLevel(bus_tx_out), .busRx(bus_rx_in), .bitTick(bitTick));

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   task automatic tallyAndFinish();
      $display("checks %0d errors %0d", nChecks, errorCnt);
      if (errorCnt == 0 && nChecks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 40000) begin
         errorCnt++;
         tallyAndFinish();
      end
   end

   function automatic logic expIrq(input logic [2:0] f, input logic [2:0] en);
      return |(f & en);
   endfunction

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
         input logic evt, output logic [31:0] rd);
      htrans <= 2'b10;
      hwrite <= wr;
      haddr <= {24'h00_0000, a};
      do @(posedge core_clk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hwdata <= wd;
      rxFgLoad <= evt;
      do @(posedge core_clk); while (hready !== 1'b1);
      rxFgLoad <= 1'b0;
      rd = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d, 1'b0, rdv);
   endtask

   task automatic chkReg(input string nm, input logic [7:0] a, input logic [31:0] x);
      xfer(1'b0, a, 32'h0000_0000, 1'b0, rdv);
      `CHK(nm, x, rdv)
   endtask

   task automatic pollReg(input logic [7:0] a, input int b, input logic v);
      for (int i = 0; i < 100; i++) begin
         xfer(1'b0, a, 32'h0000_0000, 1'b0, rdv);
         if (rdv[b] === v) break;
      end
   endtask

   task automatic waitRecover(input int lim, output int n);
      for (n = 0; n < lim; n++) begin
         @(posedge core_clk);
         if (busOffRecover === 1'b1) break;
      end
   endtask

   initial begin
      {hsel, hwrite, htrans, haddr, hwdata} = '0;
      hsize = 3'h2;
      {cpuStop, cpuWait, cpuIrqMask, rxFgLoad, rxOverrunEvt, busDom} = '0;
      {txDoneEvt, txErrState, rxErrState} = '0;
      coreTx = 1'b1;
      coreIdle = 1'b1;
      rst_n = 1'b0;
      rdv = $urandom(55400);
      tick(16);
      rst_n <= 1'b1;
      hsel <= 1'b1;
      tick(1);
      chkReg("ctrl0", OFS_CTRL0, 32'h0000_0011);
      chkReg("tflg", OFS_TFLG, 32'h0000_0007);
      chkReg("unmapped", 8'h1C, 32'h0000_0000);
      `CHK("txSchedule", 3'h0, txSchedule)
      wr(OFS_CTRL0, 32'h0000_0081);
      wr(OFS_RIER, 32'h0000_00C3);
      wr(OFS_TIER, 32'h0000_0007);
      wr(OFS_CTRL0, 32'h0000_0080);
      pollReg(OFS_CTRL0, B_INITACK, 1'b0);
      chkReg("ctrl0", OFS_CTRL0, 32'h0000_0080);
      `CHK("irqTx", 1'b1, irqTx)
      cpuIrqMask <= 1'b1;
      tick(2);
      `CHK("irqTx", 1'b0, irqTx)
      cpuIrqMask <= 1'b0;
      wr(OFS_TFLG, 32'h0000_0000);
      chkReg("tflg", OFS_TFLG, 32'h0000_0007);
      for (int i = 0; i < 8; i++) begin
         m = 3'($urandom);
         e = 3'($urandom);
         wr(OFS_TIER, {29'h0, e});
         wr(OFS_TFLG, {29'h0, m});
         tick(1);
         chkReg("tflg", OFS_TFLG, {29'h0, ~m});
         `CHK("txSchedule", m, txSchedule)
         `CHK("irqTx", expIrq(~m, e), irqTx)
         txDoneEvt <= m;
         tick(1);
         txDoneEvt <= 3'h0;
         tick(1);
         chkReg("tflg", OFS_TFLG, 32'h0000_0007);
      end
      wr(OFS_TIER, 32'h0000_0007);
      rxFgLoad <= 1'b1;
      tick(1);
      rxFgLoad <= 1'b0;
      tick(1);
      `CHK("irqRx", 1'b1, irqRx)
      wr(OFS_RFLG, 32'h0000_0000);
      chkReg("rflg", OFS_RFLG, 32'h0000_0001);
      xfer(1'b1, OFS_RFLG, 32'h0000_0001, 1'b1, rdv);
      chkReg("rflg", OFS_RFLG, 32'h0000_0001);
      wr(OFS_RFLG, 32'h0000_0001);
      chkReg("rflg", OFS_RFLG, 32'h0000_0000);
      `CHK("irqRx", 1'b0, irqRx)
      rxOverrunEvt <= 1'b1;
      tick(1);
      rxOverrunEvt <= 1'b0;
      tick(1);
      `CHK("irqErr", 1'b1, irqErr)
      chkReg("rflg", OFS_RFLG, 32'h0000_0002);
      wr(OFS_RFLG, 32'h0000_0002);
      txErrState <= 2'h1;
      rxErrState <= 2'h2;
      tick(2);
      chkReg("rflg", OFS_RFLG, 32'h0000_0064);
      `CHK("irqErr", 1'b1, irqErr)
      wr(OFS_RFLG, 32'h0000_0040);
      chkReg("rflg", OFS_RFLG, 32'h0000_0024);
      `CHK("irqErr", 1'b0, irqErr)
      {txErrState, rxErrState} <= 4'h0;
      txErrState <= ERR_BUSOFF;
      tick(2);
      `CHK("inBusOff", 1'b1, inBusOff)
      waitRecover(7000, k);
      `CHK("recovered", 1'b1, 1'(k < 7000))
      `CHK("recovery wait", 1'b1, 1'(k >= 1400 * TDIV))
      txErrState <= ERR_OK;
      wr(OFS_RFLG, 32'h0000_0040);
      wr(OFS_CTRL1, 32'h0000_0002);
      txErrState <= ERR_BUSOFF;
      tick(2);
      chkReg("misc", OFS_MISC, 32'h0000_0003);
      waitRecover(6000, k);
      `CHK("held recovery", 1'b0, 1'(k < 6000))
      wr(OFS_MISC, 32'h0000_0000);
      waitRecover(20, k);
      `CHK("released recovery", 1'b1, 1'(k < 20))
      txErrState <= ERR_OK;
      wr(OFS_RFLG, 32'h0000_0040);
      wr(OFS_CTRL0, 32'h0000_0082);
      pollReg(OFS_CTRL0, B_SLEEPACK, 1'b1);
      wr(OFS_CTRL0, 32'h0000_0083);
      pollReg(OFS_CTRL0, B_INITACK, 1'b1);
      chkReg("ctrl0", OFS_CTRL0, 32'h0000_0093);
      wr(OFS_CTRL1, 32'h0000_0001);
      wr(OFS_CTRL0, 32'h0000_0080);
      pollReg(OFS_CTRL0, B_INITACK, 1'b0);
      tick(4);
      chkReg("ctrl0", OFS_CTRL0, 32'h0000_0080);
      chkReg("ctrl1", OFS_CTRL1, 32'h0000_0001);
      wr(OFS_CTRL1, 32'h0000_0001);
      wr(OFS_CTRL0, 32'h0000_0086);
      pollReg(OFS_CTRL0, B_SLEEPACK, 1'b1);
      chkReg("ctrl0", OFS_CTRL0, 32'h0000_00A6);
      busDom <= 1'b1;
      tick(1);
      busDom <= 1'b0;
      tick(5);
      chkReg("ctrl0", OFS_CTRL0, 32'h0000_00A6);
      busDom <= 1'b1;
      tick(10);
      busDom <= 1'b0;
      tick(2);
      `CHK("irqWake", 1'b1, irqWake)
      chkReg("rflg", OFS_RFLG, 32'h0000_0080);
      pollReg(OFS_CTRL0, B_SLEEPACK, 1'b0);
      chkReg("ctrl0", OFS_CTRL0, 32'h0000_0084);
      wr(OFS_RFLG, 32'h0000_0080);
      wr(OFS_CTRL1, 32'h0000_0000);
      cpuStop <= 1'b1;
      tick(3);
      `CHK("bus_tx_out", 1'b1, bus_tx_out)
      `CHK("coreRun", 1'b0, coreRun)
      chkReg("ctrl0", OFS_CTRL0, 32'h0000_0000);
      cpuStop <= 1'b0;
      tick(RCY + 10);
      chkReg("ctrl0", OFS_CTRL0, 32'h0000_0084);
      wr(OFS_CTRL0, 32'h0000_008C);
      cpuWait <= 1'b1;
      tick(2);
      chkReg("ctrl0", OFS_CTRL0, 32'h0000_0000);
      cpuWait <= 1'b0;
      tick(RCY + 10);
      wr(OFS_CTRL0, 32'h0000_0084);
      cpuWait <= 1'b1;
      tick(2);
      chkReg("ctrl0", OFS_CTRL0, 32'h0000_0084);
      cpuWait <= 1'b0;
      wr(OFS_CTRL0, 32'h0000_0086);
      pollReg(OFS_CTRL0, B_SLEEPACK, 1'b1);
      cpuStop <= 1'b1;
      tick(2);
      busDom <= 1'b1;
      tick(6);
      `CHK("wakeUpReq", 1'b1, wakeUpReq)
      busDom <= 1'b0;
      cpuStop <= 1'b0;
      tick(4);
      tallyAndFinish();
   end
endmodule

bind cpr_ctrl cpr_ctrl_assertions chk_u (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
   .hrdata(hrdata), .hresp(hresp), .cpuStop(cpuStop), .cpuWait(cpuWait),
   .cpuIrqMask(cpuIrqMask), .txDoneEvt(txDoneEvt), .txSchedule(txSchedule),
   .coreRun(coreRun), .coreAbort(coreAbort), .busOffRecover(busOffRecover),
   .bus_tx_out(bus_tx_out), .irqWake(irqWake), .irqErr(irqErr), .irqRx(irqRx),
   .irqTx(irqTx));
